/* exec_pkg.sv */
// Package: opcodes, widths, reset values and cycle counts of the exec group
package exec_pkg;
    localparam int DATA_W     = 8;
    localparam int PC_W       = 11;
    localparam int RADDR_W    = 7;
    localparam int STACK_D    = 8;
    localparam int LVL_W      = 4;
    localparam logic [7:0]       ACC_RST = 8'h00;
    localparam logic [PC_W-1:0]  PC_RST  = 11'h000;
    localparam logic [LVL_W-1:0] LVL_RST = 4'h0;
    localparam logic [1:0] CYC_ONE = 2'h1;
    localparam logic [1:0] CYC_TWO = 2'h2;

    typedef enum logic [2:0] {
        OP_NOP      = 3'b000,
        OP_LOAD_IMM = 3'b001,
        OP_MOVE_REG = 3'b010,
        OP_RET_IRQ  = 3'b011,
        OP_RET_IMM  = 3'b100,
        OP_ROT_LEFT = 3'b101,
        OP_RET_SUB  = 3'b110
    } op_t;

    typedef enum logic [0:0] {
        ST_FETCH = 1'b0,
        ST_POP   = 1'b1
    } state_t;
endpackage

/* alu_if.sv */
// Interface: request and result between the core and its data unit
`timescale 1ns/1ps
interface alu_if;
    exec_pkg::op_t op;
    logic [7:0]    operand;
    logic          carry_in;
    logic [7:0]    result;
    logic          carry_out;
    logic          zero_out;
    modport core (output op, operand, carry_in,
                  input result, carry_out, zero_out);
    modport unit (input op, operand, carry_in,
                  output result, carry_out, zero_out);
endinterface

/* exec_alu.sv */
// Data unit: result and flag values for the move and rotate group
`timescale 1ns/1ps
module exec_alu (
    alu_if.unit a
);
    // ==========================================================
    // Result path
    always_comb begin
        a.result    = a.operand;
        a.carry_out = a.carry_in;
        if (a.op == exec_pkg::OP_ROT_LEFT) begin
            a.result    = {a.operand[6:0], a.carry_in}; // [RL7]
            a.carry_out = a.operand[7]; // [RL7]
        end
        a.zero_out = (a.result == 8'h00); // [RL4]
    end
endmodule // exec_alu

/* exec_core.sv */
// Execution core for the move, return and rotate instruction group
// How it works
// [RL1] Load-immediate puts the 8-bit immediate into the accumulator in one cycle, flags untouched.
// [RL2] No-operation changes nothing but advances the program counter by one in one cycle.
// [RL3] Move-register copies the addressed register to the accumulator (d=0) or back to itself (d=1) in one cycle.
// [RL4] Move-register sets the zero flag when the moved value is zero and clears it otherwise.
// [RL5] Return-from-irq pops the stack into the program counter, sets the global enable, drops the level, in two cycles.
// [RL6] Return-with-immediate loads the accumulator and pops the stack into the program counter in two cycles.
// [RL7] Rotate-left shifts through carry: old carry to bit 0, bits 6..0 up, old bit 7 to carry.
// [RL8] Rotate-left writes the accumulator (d=0) or the register (d=1), changes only carry, in one cycle.
// [RL9] Plain return pops the stack into the program counter and drops the level in two cycles, enable kept.
// [RL10] Instructions listing no flags keep zero, digit-carry and carry as they were.
`timescale 1ns/1ps
module exec_core #(
    parameter int STACK_D = exec_pkg::STACK_D
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 instr_valid,
    input  exec_pkg::op_t             instr_op,
    input  wire logic [7:0]           instr_imm,
    input  wire logic [6:0]           instr_raddr,
    input  wire logic                 instr_dest,
    input  wire logic [7:0]           reg_rdata,
    input  wire logic                 irq_disable,
    output logic                      instr_ready,
    output logic [6:0]                reg_waddr,
    output logic [7:0]                reg_wdata,
    output logic                      reg_we,
    output logic [7:0]                accumulator,
    output logic                      zero_flag,
    output logic                      digit_carry,
    output logic                      carry_flag,
    output logic                      global_irq_enable,
    output logic [10:0]               pc,
    output logic [3:0]                stack_level,
    output logic                      retire
);
    // ==========================================================
    // State
    exec_pkg::state_t      state_ff, nxt_state;
    logic [7:0]            acc_ff, nxt_acc;
    logic                  z_ff, nxt_z, dc_ff, c_ff, nxt_c;
    logic                  gie_ff, nxt_gie;
    logic [10:0]           pc_ff, nxt_pc;
    logic [3:0]            lvl_ff, nxt_lvl;
    logic [10:0]           stack_ff [STACK_D];
    logic [6:0]            wa_ff, nxt_wa;
    logic [7:0]            wd_ff, nxt_wd;
    logic                  we_ff, nxt_we, ret_ff, nxt_ret;
    exec_pkg::op_t         pend_ff, nxt_pend;
    logic [7:0]            pimm_ff, nxt_pimm;

    alu_if au ();
    exec_alu u_alu (.a(au));

    assign au.op       = instr_op;
    assign au.operand  = reg_rdata;
    assign au.carry_in = c_ff;

    // Wraps inside the stack so an empty pop never reads past the end
    function automatic int pop_index(input logic [3:0] lvl);
        pop_index = (int'(lvl) + STACK_D - 1) % STACK_D;
    endfunction

    // ==========================================================
    // Next state
    always_comb begin
        nxt_state = state_ff;
        nxt_acc   = acc_ff;
        nxt_z     = z_ff; // [RL10]
        nxt_c     = c_ff; // [RL10]
        nxt_gie   = gie_ff;
        nxt_pc    = pc_ff;
        nxt_lvl   = lvl_ff;
        nxt_wa    = wa_ff;
        nxt_wd    = wd_ff;
        nxt_we    = 1'b0;
        nxt_ret   = 1'b0;
        nxt_pend  = pend_ff;
        nxt_pimm  = pimm_ff;
        case (state_ff)
            exec_pkg::ST_FETCH: begin
                if (instr_valid) begin
                    nxt_pc  = pc_ff + 11'h001; // [RL2]
                    nxt_ret = 1'b1;
                    case (instr_op)
                        exec_pkg::OP_LOAD_IMM: begin
                            nxt_acc = instr_imm; // [RL1]
                        end
                        exec_pkg::OP_MOVE_REG,
                        exec_pkg::OP_ROT_LEFT: begin
                            if (instr_op == exec_pkg::OP_MOVE_REG) begin
                                nxt_z = au.zero_out; // [RL4]
                            end else begin
                                nxt_c = au.carry_out; // [RL8]
                            end
                            if (instr_dest) begin
                                nxt_we = 1'b1; // [RL3] [RL8]
                                nxt_wa = instr_raddr;
                                nxt_wd = au.result;
                            end else begin
                                nxt_acc = au.result; // [RL3] [RL8]
                            end
                        end
                        exec_pkg::OP_RET_IRQ,
                        exec_pkg::OP_RET_IMM,
                        exec_pkg::OP_RET_SUB: begin
                            // Second cycle does the pop; no new fetch meanwhile
                            nxt_ret   = 1'b0;
                            nxt_pc    = pc_ff;
                            nxt_pend  = instr_op;
                            nxt_pimm  = instr_imm;
                            nxt_state = exec_pkg::ST_POP; // [RL5] [RL6] [RL9]
                        end
                        default: begin
                        end
                    endcase
                end
            end
            exec_pkg::ST_POP: begin
                nxt_state = exec_pkg::ST_FETCH;
                nxt_ret   = 1'b1;
                // Empty stack wraps like real small cores; level stays 0
                nxt_pc    = stack_ff[pop_index(lvl_ff)]; // [RL5] [RL6] [RL9]
                if (lvl_ff != 4'h0) begin
                    nxt_lvl = lvl_ff - 4'h1; // [RL5] [RL9]
                end
                if (pend_ff == exec_pkg::OP_RET_IRQ) begin
                    nxt_gie = 1'b1; // [RL5]
                end
                if (pend_ff == exec_pkg::OP_RET_IMM) begin
                    nxt_acc = pimm_ff; // [RL6]
                end
            end
            default: nxt_state = exec_pkg::ST_FETCH;
        endcase
        if (irq_disable) begin
            nxt_gie = 1'b0;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= exec_pkg::ST_FETCH;
            acc_ff   <= exec_pkg::ACC_RST;
            z_ff     <= 1'b0;
            dc_ff    <= 1'b0;
            c_ff     <= 1'b0;
            gie_ff   <= 1'b0;
            pc_ff    <= exec_pkg::PC_RST;
            lvl_ff   <= exec_pkg::LVL_RST;
            wa_ff    <= 7'h00;
            wd_ff    <= 8'h00;
            we_ff    <= 1'b0;
            ret_ff   <= 1'b0;
            pend_ff  <= exec_pkg::OP_NOP;
            pimm_ff  <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            acc_ff   <= nxt_acc;
            z_ff     <= nxt_z;
            dc_ff    <= dc_ff; // [RL10]
            c_ff     <= nxt_c;
            gie_ff   <= nxt_gie;
            pc_ff    <= nxt_pc;
            lvl_ff   <= nxt_lvl;
            wa_ff    <= nxt_wa;
            wd_ff    <= nxt_wd;
            we_ff    <= nxt_we;
            ret_ff   <= nxt_ret;
            pend_ff  <= nxt_pend;
            pimm_ff  <= nxt_pimm;
        end
    end

    // Stack contents are only set to PC_RST at reset; no port or logic here ever loads them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < STACK_D; i++) begin
                stack_ff[i] <= exec_pkg::PC_RST;
            end
        end
    end

    assign instr_ready       = (state_ff == exec_pkg::ST_FETCH);
    assign accumulator       = acc_ff;
    assign zero_flag         = z_ff;
    assign digit_carry       = dc_ff;
    assign carry_flag        = c_ff;
    assign global_irq_enable = gie_ff;
    assign pc                = pc_ff;
    assign stack_level       = lvl_ff;
    assign reg_waddr         = wa_ff;
    assign reg_wdata         = wd_ff;
    assign reg_we            = we_ff;
    assign retire            = ret_ff;

    // ==========================================================
    // Checks
    a_load_imm_acc: assert property (@(posedge clk) disable iff (rst) // [RL1]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_LOAD_IMM
        |=> acc_ff == $past(instr_imm) && c_ff == $past(c_ff)
            && z_ff == $past(z_ff))
        else $error("load immediate wrong");
    a_nop_pc_step: assert property (@(posedge clk) disable iff (rst) // [RL2]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_NOP
        |=> pc_ff == $past(pc_ff) + 11'h001 && acc_ff == $past(acc_ff))
        else $error("nop changed state");
    a_move_dest: assert property (@(posedge clk) disable iff (rst) // [RL3]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_MOVE_REG
        && !instr_dest |=> acc_ff == $past(reg_rdata) && !reg_we)
        else $error("move to accumulator wrong");
    a_move_zero: assert property (@(posedge clk) disable iff (rst) // [RL4]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_MOVE_REG
        |=> z_ff == ($past(reg_rdata) == 8'h00))
        else $error("zero flag wrong");
    a_irq_return: assert property (@(posedge clk) disable iff (rst) // [RL5]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_RET_IRQ
        && !irq_disable ##1 !irq_disable
        |=> gie_ff && retire
        && (lvl_ff == $past(lvl_ff, 2) - 4'h1
            || ($past(lvl_ff, 2) == 4'h0 && lvl_ff == 4'h0)))
        else $error("irq return wrong");
    a_imm_return: assert property (@(posedge clk) disable iff (rst) // [RL6]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_RET_IMM
        |=> !instr_ready ##1 acc_ff == $past(instr_imm, 2) && instr_ready)
        else $error("return with immediate wrong");
    a_rotate_bits: assert property (@(posedge clk) disable iff (rst) // [RL7]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_ROT_LEFT
        && instr_dest |=> reg_we && c_ff == $past(reg_rdata[7])
        && reg_wdata == {$past(reg_rdata[6:0]), $past(c_ff)})
        else $error("rotate result wrong");
    a_rotate_flags: assert property (@(posedge clk) disable iff (rst) // [RL8]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_ROT_LEFT
        |=> z_ff == $past(z_ff) && retire)
        else $error("rotate touched zero flag");
    a_sub_return: assert property (@(posedge clk) disable iff (rst) // [RL9]
        instr_ready && instr_valid && instr_op == exec_pkg::OP_RET_SUB
        && !irq_disable ##1 !irq_disable |=> gie_ff == $past(gie_ff, 2))
        else $error("plain return changed enable");
    a_flags_kept: assert property (@(posedge clk) disable iff (rst) // [RL10]
        ##1 dc_ff == $past(dc_ff))
        else $error("digit carry changed");
    a_flags_hold: assert property (@(posedge clk) disable iff (rst) // [RL10]
        instr_ready && instr_valid && (instr_op == exec_pkg::OP_NOP
        || instr_op == exec_pkg::OP_RET_IMM)
        |=> z_ff == $past(z_ff) && c_ff == $past(c_ff))
        else $error("flag changed by flagless op");
endmodule // exec_core

/* tb_cpu_move_return_rotate_ops.sv */
// Testbench: move, return and rotate group of the execution core
`timescale 1ns/1ps
module tb_cpu_move_return_rotate_ops;
    // ==========================================================
    // Stimulus and observed signals
    logic            clk         = 1'b0;
    logic            rst         = 1'b1;
    logic            instr_valid = 1'b0;
    exec_pkg::op_t   instr_op    = exec_pkg::OP_NOP;
    logic [7:0]      instr_imm   = 8'h00;
    logic [6:0]      instr_raddr = 7'h00;
    logic            instr_dest  = 1'b0;
    logic [7:0]      reg_rdata   = 8'h00;
    logic            irq_disable = 1'b0;
    logic            instr_ready;
    logic [6:0]      reg_waddr;
    logic [7:0]      reg_wdata;
    logic            reg_we;
    logic [7:0]      accumulator;
    logic            zero_flag;
    logic            digit_carry;
    logic            carry_flag;
    logic            global_irq_enable;
    logic [10:0]     pc;
    logic [3:0]      stack_level;
    logic            retire;
    int              mismatches  = 0;
    int              checks_done = 0;

    always #50 clk = ~clk;

    exec_core dut_u (
        .clk(clk), .rst(rst), .instr_valid(instr_valid),
        .instr_op(instr_op), .instr_imm(instr_imm),
        .instr_raddr(instr_raddr), .instr_dest(instr_dest),
        .reg_rdata(reg_rdata), .irq_disable(irq_disable),
        .instr_ready(instr_ready), .reg_waddr(reg_waddr),
        .reg_wdata(reg_wdata), .reg_we(reg_we),
        .accumulator(accumulator), .zero_flag(zero_flag),
        .digit_carry(digit_carry), .carry_flag(carry_flag),
        .global_irq_enable(global_irq_enable), .pc(pc),
        .stack_level(stack_level), .retire(retire)
    );

    // ==========================================================
    // Shared tasks
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task check(input string name, input logic [10:0] seen,
               input logic [10:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Returns one ns after the edge that takes the instruction
    task issue(input exec_pkg::op_t op, input logic [7:0] imm,
               input logic [6:0] ra, input logic d, input logic [7:0] rd);
        int n;
        n = 0;
        while (instr_ready !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 4) begin
            mismatches++;
            $display("mismatch instr_ready expected 1 seen %b", instr_ready);
            final_report();
        end
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op    <= op;
        instr_imm   <= imm;
        instr_raddr <= ra;
        instr_dest  <= d;
        reg_rdata   <= rd;
        @(posedge clk);
        instr_valid <= 1'b0;
        instr_op    <= exec_pkg::OP_NOP;
        // Stale read data must not be mistaken for a live value
        reg_rdata   <= ~rd;
        #1;
    endtask

    // ==========================================================
    // Scenarios
    task t_reset;
        check("acc", 11'(accumulator), 11'h000);
        check("gie", 11'(global_irq_enable), 11'h000);
        check("pc", pc, 11'h000);
        check("ready", 11'(instr_ready), 11'h001);
    endtask

    task t_rotate_reg;
        issue(exec_pkg::OP_ROT_LEFT, 8'h00, 7'h15, 1'b1, 8'hA5);
        check("rot wdata", 11'(reg_wdata), 11'h04A);
        check("rot carry", 11'(carry_flag), 11'h001);
        check("rot we", 11'(reg_we), 11'h001);
        check("rot waddr", 11'(reg_waddr), 11'h015);
        check("rot acc", 11'(accumulator), 11'h000);
        check("rot zero", 11'(zero_flag), 11'h000);
        check("rot retire", 11'(retire), 11'h001);
        @(posedge clk);
        #1;
        check("we pulse", 11'(reg_we), 11'h000);
        check("retire pulse", 11'(retire), 11'h000);
    endtask

    task t_load_move;
        issue(exec_pkg::OP_LOAD_IMM, 8'hFF, 7'h00, 1'b0, 8'h00);
        check("li acc", 11'(accumulator), 11'h0FF);
        check("li carry", 11'(carry_flag), 11'h001);
        check("li retire", 11'(retire), 11'h001);
        issue(exec_pkg::OP_MOVE_REG, 8'h00, 7'h7F, 1'b0, 8'h00);
        check("mv acc", 11'(accumulator), 11'h000);
        check("mv zero set", 11'(zero_flag), 11'h001);
        check("mv we", 11'(reg_we), 11'h000);
        issue(exec_pkg::OP_LOAD_IMM, 8'h55, 7'h00, 1'b0, 8'h00);
        check("li zero kept", 11'(zero_flag), 11'h001);
        check("li acc2", 11'(accumulator), 11'h055);
    endtask

    task t_nop;
        logic [10:0] p;
        logic [2:0]  f;
        p = pc;
        issue(exec_pkg::OP_NOP, 8'h3C, 7'h11, 1'b1, 8'h99);
        f = {zero_flag, digit_carry, carry_flag};
        check("nop pc", pc, p + 11'h001);
        check("nop acc", 11'(accumulator), 11'h055);
        check("nop we", 11'(reg_we), 11'h000);
        check("nop flags", 11'(f), 11'h005);
    endtask

    task t_rotate_acc_selfmove;
        issue(exec_pkg::OP_ROT_LEFT, 8'h00, 7'h02, 1'b0, 8'h01);
        check("rot acc", 11'(accumulator), 11'h003);
        check("rot carry0", 11'(carry_flag), 11'h000);
        check("rot zero kept", 11'(zero_flag), 11'h001);
        check("rot no we", 11'(reg_we), 11'h000);
        issue(exec_pkg::OP_MOVE_REG, 8'h00, 7'h7F, 1'b1, 8'h5A);
        check("self we", 11'(reg_we), 11'h001);
        check("self addr", 11'(reg_waddr), 11'h07F);
        check("self data", 11'(reg_wdata), 11'h05A);
        check("self acc", 11'(accumulator), 11'h003);
        check("self zero", 11'(zero_flag), 11'h000);
    endtask

    task t_return(input exec_pkg::op_t op, input logic [7:0] imm,
                  input logic [7:0] acc_x, input logic gie_x);
        issue(op, imm, 7'h00, 1'b0, 8'h00);
        check("ret busy", 11'(instr_ready), 11'h000);
        check("ret early", 11'(retire), 11'h000);
        @(posedge clk);
        #1;
        check("ret retire", 11'(retire), 11'h001);
        check("ret pc", pc, 11'h000);
        check("ret level", 11'(stack_level), 11'h000);
        check("ret acc", 11'(accumulator), 11'(acc_x));
        check("ret gie", 11'(global_irq_enable), 11'(gie_x));
        check("ret carry", 11'(carry_flag), 11'h000);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        #1;
        t_reset();
        t_rotate_reg();
        t_load_move();
        t_nop();
        t_rotate_acc_selfmove();
        t_return(exec_pkg::OP_RET_IMM, 8'hC3, 8'hC3, 1'b0);
        t_return(exec_pkg::OP_RET_IRQ, 8'h00, 8'hC3, 1'b1);
        t_return(exec_pkg::OP_RET_SUB, 8'h00, 8'hC3, 1'b1);
        @(posedge clk);
        irq_disable <= 1'b1;
        @(posedge clk);
        irq_disable <= 1'b0;
        #1;
        check("gie off", 11'(global_irq_enable), 11'h000);
        final_report();
    end
endmodule // tb_cpu_move_return_rotate_ops
